// ### hdl/fws_defines.svh
`ifndef FWS_DEFINES_SVH
`define FWS_DEFINES_SVH
// ****************************************************************
// link opcodes
// ****************************************************************
`define FWS_OP_SET_LATCH  8'h06
`define FWS_OP_CLR_LATCH  8'h04
`define FWS_OP_VOL_ENABLE 8'h50
`define FWS_OP_SR_READ_LO 8'h05
`define FWS_OP_SR_READ_HI 8'h35
`define FWS_OP_SR_WRITE   8'h01
`define FWS_OP_SR_WRITE_H 8'h31
`define FWS_OP_CFG_WRITE  8'h11
`define FWS_OP_PG_PROG    8'h02
`define FWS_OP_QPG_PROG   8'h32
`define FWS_OP_PG_ERASE   8'h81
`define FWS_OP_SCT_ERASE  8'h20
`define FWS_OP_HBLK_ERASE 8'h52
`define FWS_OP_BLK_ERASE  8'hD8
`define FWS_OP_CHIP_ER_A  8'hC7
`define FWS_OP_CHIP_ER_B  8'h60
`define FWS_OP_BUF_PROG   8'h9D
`define FWS_OP_SEC_ERASE  8'h44
`define FWS_OP_SEC_PROG   8'h42
`define FWS_OP_SUSPEND    8'h75
`define FWS_OP_RESUME     8'h7A
`define FWS_OP_SW_RESET   8'h99
// ****************************************************************
// status bit positions and reset
// ****************************************************************
`define FWS_SB_BUSY   0
`define FWS_SB_LATCH  1
`define FWS_SB_SEL0   7
`define FWS_SB_SEL1   8
`define FWS_SB_QUAD   9
`define FWS_SB_FAIL   10
`define FWS_SB_CMP    14
`define FWS_SB_SUS    15
`define FWS_SR_RESET  16'h0000
// ****************************************************************
// timing: clock rate, self-timed cycle, link half period
// ****************************************************************
`define FWS_CLK_MHZ     10
`define FWS_T_BUSY_US   2
`define FWS_BUSY_CYCLES (`FWS_T_BUSY_US * `FWS_CLK_MHZ)
`define FWS_HALF_CYCLES 8
// ****************************************************************
// controller register offsets and control fields
// ****************************************************************
`define FWS_R_OP     8'h00
`define FWS_R_ADDR   8'h04
`define FWS_R_WDATA  8'h08
`define FWS_R_CTRL   8'h0C
`define FWS_R_STAT   8'h10
`define FWS_R_RX     8'h14
`define FWS_C_ADDR   0
`define FWS_C_NWR_LO 1
`define FWS_C_NRD_LO 3
`define FWS_C_QUAD   5
`define FWS_C_WP     6
`endif

// ### hdl/fws_pkg.sv
package fws_pkg;
  // controller sequence states
  typedef enum logic [1:0] {
    FWS_IDLE = 2'b00,
    FWS_RUN  = 2'b01,
    FWS_END  = 2'b10,
    FWS_GAP  = 2'b11
  } fws_state_e;

  // device end state
  typedef struct packed {
    logic [2:0]  sclk_s;   // sync stage 1, stage 2, previous
    logic [2:0]  cs_s;
    logic [3:0]  io_s1;
    logic [3:0]  io_s2;
    logic [5:0]  cnt;      // bits taken this frame
    logic [47:0] sh;
    logic [7:0]  op;
    logic [23:0] addr;
    logic        rd;
    logic [7:0]  tx;
    logic [2:0]  ocnt;
    logic [3:0]  io_o;
    logic [3:0]  io_oe;
    logic [15:0] sr;
    logic        vol;
    logic        pe_kind;
    logic [15:0] bt;
    logic        op_start;
    logic [7:0]  op_code;
    logic [23:0] op_addr;
  } fws_dev_s;

  // controller end state
  typedef struct packed {
    fws_state_e  st;
    logic [7:0]  div;
    logic        sclk;
    logic        cs_n;
    logic [5:0]  ccnt;
    logic [5:0]  nclk;
    logic [5:0]  sclks;
    logic [47:0] sh;
    logic [3:0]  io_o;
    logic [3:0]  io_oe;
    logic [3:0]  io_s1;
    logic [3:0]  io_s2;
    logic [15:0] rx;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [6:0]  cfg;
    logic [31:0] rdata;
  } fws_host_s;
endpackage

// ### hdl/fws_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fws_link_if;
  logic       sclk;   // link clock, controller made
  logic       cs_n;   // frame select, active low
  logic [3:0] h_o;    // controller lane drive
  logic [3:0] h_oe;
  logic [3:0] d_o;    // device lane drive
  logic [3:0] d_oe;
  logic [3:0] io;     // resolved lanes, pulled high when free
  assign io = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe);
  modport host (output sclk, output cs_n, output h_o, output h_oe, input io);
  modport dev (input sclk, input cs_n, input io, output d_o, output d_oe);
endinterface
`default_nettype wire

// ### hdl/fws_device.sv
// Summary of operation
// - four-lane: opcode, address, data upper nibble first
// - security address: page 01/02/03 in bits 15..12, bits 11..10 zero
// - opcode 06 alone sets write latch
// - controller re-arms latch before each modifying command
// - opcode 04 alone clears write latch
// - latch cleared at reset and on completions
// - opcode 50 enables volatile write, clears latch
// - status readable any time, even while busy
// - 05 gives bits 7..0, 35 bits 15..8
// - controller polls busy before new commands
// - fixed status bit layout
// - busy high only during self-timed cycle
// - latch clear rejects writes, programs, erases
// - protect bits guard region, writable if unlocked
// - chip erase only with no protected region
// - select 00 free, 01 follows protect pin
// - select 10 until power cycle, 11 forever; here reset loads 0000 and clears 11 as well
// - quad enable turns pin functions into lanes
// - fail flag on failure, cleared on success
// - security locks only ever set
// - status write leaves bits 15,10,1,0 alone
// - suspend flag set by 75, cleared by 7A
// - status write only on byte boundary
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "fws_defines.svh"
`default_nettype none
module fws_device #(
  parameter int BUSY_CYCLES = `FWS_BUSY_CYCLES
) (
  input  wire logic        rst,
  input  wire logic        ref_clk,
  fws_link_if.dev          link,
  input  wire logic        four_lane_mode,
  input  wire logic        target_protected,
  input  wire logic        array_fail,
  output logic [15:0]      status,
  output logic             op_start,
  output logic [7:0]       op_code,
  output logic [23:0]      op_addr
);
  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin : g_chk
    $error("BUSY_CYCLES out of range");
  end

  fws_pkg::fws_dev_s d;      // registered state
  fws_pkg::fws_dev_s next_d; // next state

  // ****************************************************************
  // helpers
  // ****************************************************************
  // security register index from an address, zero when none
  function automatic logic [1:0] sec_index(input logic [23:0] a);
    sec_index = 2'b00;
    if (a[23:16] == 8'h00 && a[15:14] == 2'b00 && a[11:10] == 2'b00 && a[13:12] != 2'b00)
    begin
      sec_index = a[13:12];
    end
  endfunction

  // status byte for a read opcode
  function automatic logic [7:0] read_byte(input logic [7:0] o, input logic [15:0] s);
    read_byte = (o == `FWS_OP_SR_READ_HI) ? s[15:8] : s[7:0];
  endfunction

  // protect select and pin decide if status may be written
  function automatic logic wr_ok(input logic [15:0] s, input logic wp);
    case ({s[`FWS_SB_SEL1], s[`FWS_SB_SEL0]})
      2'b00:   wr_ok = 1'b1;
      2'b01:   wr_ok = wp;
      default: wr_ok = 1'b0;
    endcase
  endfunction

  // program and erase class opcodes
  function automatic logic is_pe(input logic [7:0] o);
    case (o)
      `FWS_OP_PG_PROG, `FWS_OP_QPG_PROG, `FWS_OP_PG_ERASE, `FWS_OP_SCT_ERASE,
      `FWS_OP_HBLK_ERASE, `FWS_OP_BLK_ERASE, `FWS_OP_CHIP_ER_A,
      `FWS_OP_CHIP_ER_B, `FWS_OP_BUF_PROG, `FWS_OP_SEC_ERASE,
      `FWS_OP_SEC_PROG: is_pe = 1'b1;
      default:          is_pe = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic        lanes4;   // four-lane transfer active
    logic        hold;     // hold pin pauses the clock
    logic        wp;       // effective protect pin level
    logic        rise;
    logic        fall;
    logic [47:0] sh_n;
    logic [5:0]  cnt_n;
    logic        chip;
    logic        prot;
    logic [1:0]  sidx;
    logic        sr_ok;
    next_d = d;
    next_d.op_start = 1'b0;
    // two-flop synchronisers, stage one read only by stage two
    next_d.sclk_s = {d.sclk_s[1], d.sclk_s[0], link.sclk};
    next_d.cs_s   = {d.cs_s[1], d.cs_s[0], link.cs_n};
    next_d.io_s1  = link.io;
    next_d.io_s2  = d.io_s1;
    lanes4 = four_lane_mode & d.sr[`FWS_SB_QUAD];
    hold   = ~d.sr[`FWS_SB_QUAD] & ~d.io_s2[3];
    wp     = d.sr[`FWS_SB_QUAD] | d.io_s2[2];
    rise   = d.sclk_s[1] & ~d.sclk_s[2] & ~hold;
    fall   = ~d.sclk_s[1] & d.sclk_s[2] & ~hold;
    sh_n   = lanes4 ? {d.sh[43:0], d.io_s2} : {d.sh[46:0], d.io_s2[0]};
    cnt_n  = d.cnt + (lanes4 ? 6'd4 : 6'd1);
    chip   = (d.op == `FWS_OP_CHIP_ER_A) || (d.op == `FWS_OP_CHIP_ER_B);
    sidx   = sec_index(d.addr);
    sr_ok  = (d.sr[`FWS_SB_LATCH] | d.vol) & wr_ok(d.sr, wp) & ~d.sr[`FWS_SB_BUSY];
    // protection check for the pending program or erase
    if (chip)
    begin
      prot = |d.sr[6:2];
    end
    else if (d.op == `FWS_OP_SEC_ERASE || d.op == `FWS_OP_SEC_PROG)
    begin
      prot = (sidx == 2'b00) || d.sr[`FWS_SB_FAIL + {2'b00, sidx}];
    end
    else
    begin
      prot = target_protected;
    end

    // self-timed cycle countdown
    if (d.sr[`FWS_SB_BUSY])
    begin
      next_d.bt = d.bt - 16'd1;
      if (d.bt == 16'd1)
      begin
        next_d.sr[`FWS_SB_BUSY]  = 1'b0;
        next_d.sr[`FWS_SB_LATCH] = 1'b0;
        if (d.pe_kind)
        begin
          next_d.sr[`FWS_SB_FAIL] = array_fail;
        end
      end
    end

    if (d.cs_s[2] & ~d.cs_s[1])
    begin
      // frame opens
      next_d.cnt  = 6'd0;
      next_d.ocnt = 3'd0;
      next_d.rd   = 1'b0;
    end
    else if (~d.cs_s[1])
    begin
      // inside a frame: take lanes on rise
      if (rise)
      begin
        next_d.sh = sh_n;
        if (d.cnt != 6'h3C)
        begin
          next_d.cnt = cnt_n; // saturates on long data
        end
        if (cnt_n == 6'd8)
        begin
          next_d.op = sh_n[7:0];
          if (sh_n[7:0] == `FWS_OP_SR_READ_LO || sh_n[7:0] == `FWS_OP_SR_READ_HI)
          begin
            next_d.rd = 1'b1;
            next_d.tx = read_byte(sh_n[7:0], d.sr);
          end
        end
        if (cnt_n == 6'd32)
        begin
          next_d.addr = sh_n[23:0];
        end
      end
      // drive status on fall, upper bits first
      if (fall && d.rd)
      begin
        next_d.io_oe = lanes4 ? 4'hF : 4'h2;
        next_d.io_o  = lanes4 ? d.tx[7:4] : {2'b00, d.tx[7], 1'b0};
        next_d.ocnt  = d.ocnt + (lanes4 ? 3'd4 : 3'd1);
        next_d.tx    = lanes4 ? {d.tx[3:0], 4'h0} : {d.tx[6:0], 1'b0};
        if (next_d.ocnt == 3'd0)
        begin
          next_d.tx = read_byte(d.op, d.sr); // live refresh, repeats
        end
      end
    end
    else if (~d.cs_s[2] & d.cs_s[1])
    begin
      // frame closes: act on what was taken
      next_d.rd    = 1'b0;
      next_d.io_oe = 4'h0;
      next_d.vol   = 1'b0;
      if (d.cnt >= 6'd8)
      begin
        case (d.op)
          `FWS_OP_SET_LATCH:
          begin
            if (d.cnt == 6'd8) next_d.sr[`FWS_SB_LATCH] = 1'b1;
          end
          `FWS_OP_CLR_LATCH:
          begin
            if (d.cnt == 6'd8) next_d.sr[`FWS_SB_LATCH] = 1'b0;
          end
          `FWS_OP_VOL_ENABLE:
          begin
            if (d.cnt == 6'd8)
            begin
              next_d.vol               = 1'b1;
              next_d.sr[`FWS_SB_LATCH] = 1'b0;
            end
          end
          `FWS_OP_SUSPEND: next_d.sr[`FWS_SB_SUS] = 1'b1;
          `FWS_OP_RESUME:  next_d.sr[`FWS_SB_SUS] = 1'b0;
          `FWS_OP_SW_RESET: next_d.sr[`FWS_SB_LATCH] = 1'b0;
          `FWS_OP_SR_WRITE, `FWS_OP_SR_WRITE_H, `FWS_OP_CFG_WRITE:
          begin
            // boundary, latch and protect mode all must agree
            if (sr_ok && (d.cnt == 6'd16 ||
                (d.op == `FWS_OP_SR_WRITE && d.cnt == 6'd24)))
            begin
              if (d.op == `FWS_OP_SR_WRITE)
              begin
                next_d.sr[7:2] = (d.cnt == 6'd16) ? d.sh[7:2] : d.sh[15:10];
                if (d.cnt == 6'd16)
                begin
                  next_d.sr[`FWS_SB_CMP]  = 1'b0;
                  next_d.sr[`FWS_SB_QUAD] = 1'b0;
                  next_d.sr[`FWS_SB_SEL1] = 1'b0;
                end
              end
              if ((d.op == `FWS_OP_SR_WRITE && d.cnt == 6'd24) || d.op == `FWS_OP_SR_WRITE_H)
              begin
                next_d.sr[9:8]   = d.sh[1:0];
                next_d.sr[13:11] = d.sr[13:11] | d.sh[5:3];
                next_d.sr[`FWS_SB_CMP] = d.sh[6];
              end
              // volatile writes land at once, no cycle
              if (!d.vol)
              begin
                next_d.sr[`FWS_SB_BUSY] = 1'b1;
                next_d.bt      = BUSY_CYCLES[15:0];
                next_d.pe_kind = 1'b0;
              end
            end
          end
          default:
          begin
            if (is_pe(d.op) && d.sr[`FWS_SB_LATCH] && !d.sr[`FWS_SB_BUSY] &&
                (chip ? d.cnt == 6'd8 : d.cnt >= 6'd32))
            begin
              if (prot)
              begin
                next_d.sr[`FWS_SB_FAIL] = 1'b1;
              end
              else
              begin
                next_d.sr[`FWS_SB_BUSY] = 1'b1;
                next_d.bt       = BUSY_CYCLES[15:0];
                next_d.pe_kind  = 1'b1;
                next_d.op_start = 1'b1;
                next_d.op_code  = d.op;
                next_d.op_addr  = d.addr;
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      d        <= '0;
      d.sclk_s <= 3'b000;
      d.cs_s   <= 3'b111;
      d.io_s1  <= 4'hF;
      d.io_s2  <= 4'hF;
      d.sr     <= `FWS_SR_RESET; // power cycle
    end
    else
    begin
      d <= next_d;
    end
  end

  assign link.d_o  = d.io_o;
  assign link.d_oe = d.io_oe;
  assign status    = d.sr;
  assign op_start  = d.op_start;
  assign op_code   = d.op_code;
  assign op_addr   = d.op_addr;
endmodule // fws_device
`default_nettype wire

// ### hdl/fws_host.sv
`timescale 1ns/1ps
`include "fws_defines.svh"
`default_nettype none
module fws_host #(
  parameter int HALF_CYCLES = `FWS_HALF_CYCLES
) (
  input  wire logic        rst,
  input  wire logic        ref_clk,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  fws_link_if.host         link
);
  // ****************************************************************
  // elaboration check
  // ****************************************************************
  // device answers three clocks after a fall; the half period
  // must cover that plus our own synchroniser
  if (HALF_CYCLES < 8 || HALF_CYCLES > 255) begin : g_chk
    $error("HALF_CYCLES out of range");
  end

  fws_pkg::fws_host_s h;      // registered state
  fws_pkg::fws_host_s next_h; // next state

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic       quad;
    logic       tick;
    logic [5:0] sbits;
    logic [5:0] rbits;
    next_h = h;
    next_h.io_s1 = link.io;
    next_h.io_s2 = h.io_s1;
    quad  = h.cfg[`FWS_C_QUAD];
    tick  = (h.div == 8'(HALF_CYCLES - 1));
    next_h.div = (h.st == fws_pkg::FWS_IDLE || tick) ? 8'h00 : h.div + 8'h01;
    sbits = 6'd8 + (h.cfg[`FWS_C_ADDR] ? 6'd24 : 6'd0) + {1'b0, h.cfg[2:1], 3'b000};
    rbits = {1'b0, h.cfg[4:3], 3'b000};

    // register reads, answer one cycle later
    next_h.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `FWS_R_OP:    next_h.rdata = {24'h0, h.op};
        `FWS_R_ADDR:  next_h.rdata = {8'h0, h.addr};
        `FWS_R_WDATA: next_h.rdata = {16'h0, h.wdata};
        `FWS_R_CTRL:  next_h.rdata = {25'h0, h.cfg};
        `FWS_R_STAT:  next_h.rdata = {31'h0, h.st != fws_pkg::FWS_IDLE};
        `FWS_R_RX:    next_h.rdata = {16'h0, h.rx};
        default:      next_h.rdata = 32'h0000_0000;
      endcase
    end
    // register writes; control starts a frame when idle
    if (reg_wr)
    begin
      case (reg_addr)
        `FWS_R_OP:    next_h.op    = reg_wdata[7:0];
        `FWS_R_ADDR:  next_h.addr  = reg_wdata[23:0];
        `FWS_R_WDATA: next_h.wdata = reg_wdata[15:0];
        `FWS_R_CTRL:
        begin
          if (h.st == fws_pkg::FWS_IDLE)
          begin
            next_h.cfg = reg_wdata[6:0];
            next_h.st  = fws_pkg::FWS_RUN;
          end
        end
        default: ;
      endcase
    end

    case (h.st)
      fws_pkg::FWS_IDLE:
      begin
        // load frame at start: opcode, address, data bytes in order
        next_h.cs_n = next_h.st == fws_pkg::FWS_IDLE;
        next_h.ccnt = 6'd0;
        next_h.sh = reg_wdata[`FWS_C_ADDR] ? {h.op, h.addr, h.wdata[7:0], h.wdata[15:8]}
                                           : {h.op, h.wdata[7:0], h.wdata[15:8], 24'h0};
        sbits = 6'd8 + (reg_wdata[`FWS_C_ADDR] ? 6'd24 : 6'd0) + {1'b0, reg_wdata[2:1], 3'b000};
        rbits = {1'b0, reg_wdata[4:3], 3'b000};
        next_h.sclks = reg_wdata[`FWS_C_QUAD] ? {2'b00, sbits[5:2]} : sbits;
        next_h.nclk  = reg_wdata[`FWS_C_QUAD] ? {2'b00, sbits[5:2]} + {2'b00, rbits[5:2]}
                                              : sbits + rbits;
        next_h.io_o  = reg_wdata[`FWS_C_QUAD] ? next_h.sh[47:44]
                                              : {1'b1, reg_wdata[`FWS_C_WP], 1'b0, next_h.sh[47]};
        next_h.io_oe = (next_h.st == fws_pkg::FWS_IDLE) ? 4'h0
                                                        : (reg_wdata[`FWS_C_QUAD] ? 4'hF : 4'hD);
      end
      fws_pkg::FWS_RUN:
      begin
        if (tick && !h.sclk)
        begin
          // rising edge: take read data after the send part
          next_h.sclk = 1'b1;
          next_h.ccnt = h.ccnt + 6'd1;
          if (h.ccnt >= h.sclks)
          begin
            next_h.rx = quad ? {h.rx[11:0], h.io_s2} : {h.rx[14:0], h.io_s2[1]};
          end
        end
        else if (tick)
        begin
          // falling edge: next bits or end of frame
          next_h.sclk = 1'b0;
          next_h.sh   = quad ? {h.sh[43:0], 4'h0} : {h.sh[46:0], 1'b0};
          next_h.io_o = quad ? next_h.sh[47:44] : {1'b1, h.cfg[`FWS_C_WP], 1'b0, next_h.sh[47]};
          if (h.ccnt == h.nclk)
          begin
            next_h.st = fws_pkg::FWS_END;
          end
          else if (h.ccnt >= h.sclks && quad)
          begin
            next_h.io_oe = 4'h0; // hand lanes to the device
          end
        end
        if (rbits == 6'd0 && sbits == 6'd0)
        begin
          next_h.st = fws_pkg::FWS_END;
        end
      end
      fws_pkg::FWS_END:
      begin
        // select rises only on a whole byte boundary
        if (tick)
        begin
          next_h.cs_n  = 1'b1;
          next_h.io_oe = 4'h0;
          next_h.st    = fws_pkg::FWS_GAP;
        end
      end
      fws_pkg::FWS_GAP:
      begin
        // keeps select high for one half period
        if (tick) next_h.st = fws_pkg::FWS_IDLE;
      end
      default: next_h.st = fws_pkg::FWS_IDLE;
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      h       <= '0;
      h.cs_n  <= 1'b1;
      h.io_s1 <= 4'hF;
      h.io_s2 <= 4'hF;
    end
    else
    begin
      h <= next_h;
    end
  end

  assign reg_rdata = h.rdata;
  assign link.sclk = h.sclk;
  assign link.cs_n = h.cs_n;
  assign link.h_o  = h.io_o;
  assign link.h_oe = h.io_oe;
endmodule // fws_host
`default_nettype wire

// ### bench/fws_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// link wire checker
// ****
module fws_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] h_o,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_o,
  input wire logic [3:0] d_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // one link phase is eight ref cycles
  sequence high_phase;
    sclk[*8] ##1 !sclk;
  endsequence
  sequence lead_in;
    !sclk[*8];
  endsequence
  a_idle_clock_low: assert property (cs_n |-> !sclk) else $error("link clock moves outside frame");
  a_frame_lead: assert property ($fell(cs_n) |-> lead_in) else $error("frame opens with early edge");
  a_clock_half: assert property ($rose(sclk) |-> high_phase) else $error("link high phase length");
  a_host_hold: assert property (sclk && $past(sclk) && !cs_n |-> $stable(h_o & h_oe))
    else $error("host lanes move while clock high");
  a_dev_hold: assert property (sclk && $past(sclk) |-> $stable(d_o & d_oe))
    else $error("device lanes move while clock high");
  // sync lag in the device allows a few cycles before release
  a_dev_release: assert property (cs_n[*8] |-> d_oe == 4'h0) else $error("device drives outside frame");
  a_no_fight: assert property ((h_oe & d_oe) == 4'h0) else $error("both ends drive one lane");
  a_out_lanes: assert property (d_oe != 4'h0 |-> d_oe == 4'h2 || d_oe == 4'hF)
    else $error("device drives wrong lanes");
endmodule // fws_checker
`default_nettype wire

// ### bench/flash_write_enable_status_register_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fws_defines.svh"
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value at %0t: %h vs %h", $time, a, e); \
    end \
  end
module flash_write_enable_status_register_test;
  logic        ref_clk;
  logic        rst       = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] status;
  logic        op_start;
  logic [23:0] op_addr;
  logic [7:0]  op_code;
  logic        four_lane_mode   = 1'b0;
  logic        target_protected = 1'b0;
  logic        array_fail       = 1'b0;
  int          checked   = 0;
  int          bad_count = 0;
  int          starts    = 0;  // accepted program/erase pulses
  // ****
  // ends joined across the link
  // ****
  fws_link_if link ();
  fws_host #(.HALF_CYCLES(8)) i_fws_host (.rst(rst), .ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
  // short busy cycle keeps the run brief
  fws_device #(.BUSY_CYCLES(4)) i_fws_device (.rst(rst), .ref_clk(ref_clk), .link(link),
    .four_lane_mode(four_lane_mode), .target_protected(target_protected), .array_fail(array_fail),
    .status(status), .op_start(op_start), .op_code(op_code), .op_addr(op_addr));
  fws_checker i_fws_checker (.ref_clk(ref_clk), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n),
    .h_o(link.h_o), .h_oe(link.h_oe), .d_o(link.d_o), .d_oe(link.d_oe));
  // count program/erase starts
  always @(posedge ref_clk)
    if (op_start === 1'b1)
      starts <= starts + 1;
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ****
  // register bus cycles
  // ****
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  // one link frame, then wait out host and device busy
  task frame(input logic [7:0] op, input logic [31:0] ctl);
    logic [31:0] d;
    int          n;
    wr(`FWS_R_OP, {24'h0, op});
    wr(`FWS_R_CTRL, ctl | 32'h40);  // protect pin held high
    n = 0;
    do
    begin
      rd(`FWS_R_STAT, d);
      n++;
    end
    while (d[0] !== 1'b0 && n < 400);
    while (status[0] !== 1'b0 && n < 500)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 400)
      bad_count++;
  endtask
  task sr(input logic [7:0] op, input logic [7:0] e);
    logic [31:0] d;
    frame(op, four_lane_mode ? 32'h28 : 32'h08);
    rd(`FWS_R_RX, d);
    `CHK(d[7:0], e)
  endtask
  // ****
  // scenarios
  // ****
  task t_reject;
    `CHK(status, 16'h0000)
    wr(`FWS_R_ADDR, 32'h100);
    frame(8'h02, 32'h01);
    wr(`FWS_R_WDATA, 32'hFC);
    frame(8'h01, 32'h02);
    `CHK(status, 16'h0000)
    `CHK(starts, 0)
  endtask
  task t_latch;
    frame(8'h06, 32'h0);
    sr(8'h05, 8'h02);
    frame(8'h04, 32'h0);
    sr(8'h05, 8'h00);
  endtask
  // volatile path: no latch, no busy
  task t_vol;
    frame(8'h06, 32'h0);
    frame(8'h50, 32'h0);
    `CHK(status, 16'h0000)
    wr(`FWS_R_WDATA, 32'h0C);
    frame(8'h01, 32'h02);
    `CHK(status, 16'h000C)
  endtask
  task t_write;
    frame(8'h06, 32'h0);
    frame(8'h01, 32'h0);  // no data byte: discarded
    `CHK(status, 16'h000E)
    wr(`FWS_R_WDATA, 32'hC47F);
    frame(8'h01, 32'h04);
    `CHK(status, 16'h407C)
    sr(8'h35, 8'h40);
    frame(8'h06, 32'h0);
    frame(8'h60, 32'h0);  // chip erase with region guarded
    `CHK(status, 16'h447E)
    `CHK(starts, 0)
    wr(`FWS_R_WDATA, 32'h00);
    frame(8'h01, 32'h02);
    `CHK(status, 16'h0400)
    frame(8'h06, 32'h0);
    frame(8'h02, 32'h01);
    `CHK(status, 16'h0000)
    `CHK(starts, 1)
    `CHK(op_addr, 24'h000100)
  endtask
  // four-lane frames, guarded target, security page, suspend
  task t_quad;
    frame(8'h06, 32'h0);
    wr(`FWS_R_WDATA, 32'h02);
    frame(8'h31, 32'h02);
    `CHK(status, 16'h0200)
    @(posedge ref_clk) four_lane_mode <= 1'b1;
    frame(8'h06, 32'h20);
    sr(8'h05, 8'h02);
    wr(`FWS_R_ADDR, 32'h5A3C96);
    @(posedge ref_clk) target_protected <= 1'b1;
    frame(8'h02, 32'h21);
    `CHK(status, 16'h0602)
    `CHK(starts, 1)
    @(posedge ref_clk) target_protected <= 1'b0;
    frame(8'h02, 32'h21);
    `CHK(status, 16'h0200)
    `CHK(op_addr, 24'h5A3C96)
    `CHK(op_code, 8'h02)
    frame(8'h06, 32'h20);
    wr(`FWS_R_ADDR, 32'h002000);
    @(posedge ref_clk) array_fail <= 1'b1;
    frame(8'h44, 32'h21);
    `CHK(starts, 3)
    `CHK(status, 16'h0600)
    frame(8'h75, 32'h20);
    `CHK(status, 16'h8600)
    frame(8'h7A, 32'h20);
    `CHK(status, 16'h0600)
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog well above the expected run
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    t_reject;
    t_latch;
    t_vol;
    t_write;
    t_quad;
    report_and_stop;
  end
endmodule // flash_write_enable_status_register_test
`default_nettype wire
